// file: rtl/conv_cfg.svh
// offsets, field positions, reset values and code tables of the output configuration bank
// assumes an 8-bit address, 8-bit data serial frame, msb first
`ifndef CONV_CFG_SVH
`define CONV_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define REG_RESET_READBACK 8'h00
`define REG_CLK_DRIVE 8'h10
`define REG_DRIVER 8'h11
`define REG_TERM 8'h12
`define REG_OFFSET_HOLD 8'h13

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_READBACK 0
`define BIT_SOFT_RESET 1
`define POS_CLK_STR_HI 7
`define POS_CLK_STR_LO 6
`define POS_DAT_STR_HI 1
`define POS_DAT_STR_LO 0
`define POS_AMPS_HI 3
`define POS_AMPS_LO 2
`define POS_DBL_HI 5
`define POS_DBL_LO 4
`define POS_DTERM_HI 5
`define POS_DTERM_LO 3
`define POS_CTERM_HI 2
`define POS_CTERM_LO 0
`define BIT_FREEZE 4

// ****************************************************************
// reset values and fixed levels
// ****************************************************************
`define CFG_RESET_VALUE 18'h0_0000
`define SDO_FIXED_LEVEL 1'h0

// ****************************************************************
// frame timing, in serial clock edges
// ****************************************************************
`define ADDR_BITS 5'h08
`define FRAME_BITS 5'h10

// ****************************************************************
// driver current in quarter milliamps
// ****************************************************************
`define AMPS_CODE0 8'h0e
`define AMPS_CODE1 8'h0a
`define AMPS_CODE2 8'h12
`define AMPS_CODE3 8'h07

// ****************************************************************
// termination in ohms, zero for none
// ****************************************************************
`define OHMS_CODE0 9'h000
`define OHMS_CODE1 9'h12c
`define OHMS_CODE2 9'h0b4
`define OHMS_CODE3 9'h06e
`define OHMS_CODE4 9'h096
`define OHMS_CODE5 9'h064
`define OHMS_CODE6 9'h051
`define OHMS_CODE7 9'h03c

// ****************************************************************
// offset estimator averaging shift
// ****************************************************************
`define OFS_AVG_SHIFT 8

`endif

// file: rtl/conv_pkg.sv
// types shared by the output configuration bank and the bench
// assumes conv_cfg.svh holds the numeric constants
package conv_pkg;

  // ****************************************************************
  // stored configuration fields
  // ****************************************************************
  typedef struct packed {
    logic readback_en;
    logic [1:0] clk_str;
    logic [1:0] dbl;
    logic [1:0] amps;
    logic [1:0] dat_str;
    logic [2:0] dterm;
    logic [2:0] cterm;
    logic freeze;
    logic [1:0] spare;
  } cfg_t;

  typedef enum logic [1:0] {
    DRV_WEAK = 2'b00,
    DRV_DEFAULT = 2'b01,
    DRV_STRONG = 2'b10,
    DRV_MAX = 2'b11
  } drive_level_t;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_ADDR = 2'b01,
    FR_DATA = 2'b10,
    FR_DONE = 2'b11
  } frame_state_t;

endpackage : conv_pkg

// file: rtl/offset_tracker.sv
// offset estimator and canceller for one sample stream
// assumes samples come from logic on mclk; freeze comes from the config bank
`timescale 1ns/1ns
`include "conv_cfg.svh"

module offset_tracker #(
  parameter int W = 14,
  parameter int K = `OFS_AVG_SHIFT
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic freeze,
  input wire logic sample_valid,
  input wire logic signed [W-1:0] sample_in,
  output logic sample_out_valid,
  output logic signed [W:0] sample_out
);

  typedef struct packed {
    logic [W+K-1:0] acc;
    logic out_valid;
    logic [W:0] out;
  } trk_t;

  trk_t s_reg;
  trk_t s_next;
  logic [W-1:0] est;
  logic [W:0] diff;
  logic [W+K:0] sum;

  assign est = s_reg.acc[W+K-1:K];
  assign diff = {sample_in[W-1], sample_in} - {est[W-1], est};
  assign sum = {s_reg.acc[W+K-1], s_reg.acc} + {{K{diff[W]}}, diff};

  // ****************************************************************
  // estimate and subtract
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.out_valid = sample_valid;
    if (sample_valid) begin
      s_next.out = diff;
      if (!freeze) begin
        s_next.acc = sum[W+K-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sample_out_valid = s_reg.out_valid;
  assign sample_out = s_reg.out;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_freeze_holds_estimate: assert property (freeze |=> $stable(est))
    else $error("offset estimate moved while frozen");
  chk_estimate_subtracted: assert property (sample_valid |=> sample_out ==
    ({$past(sample_in[W-1]), $past(sample_in)} - {$past(est[W-1]), $past(est)}))
    else $error("output is not sample minus estimate");
  cov_frozen_sample: cover property (freeze && sample_valid);

endmodule : offset_tracker

// file: rtl/converter_output_config_regs.sv
// output configuration register bank reached over the serial configuration pins
// assumes sen_n, sclk and sdata are asynchronous pins; samples arrive on mclk
//
// Function
// - writing one to the reset bit at address zero returns every register to default and the bit reads back zero.
// - with readback disabled the serial output pin is held at a fixed level, never released.
// - with readback enabled the serial output pin shifts out the addressed register contents.
// - the output clock drive field selects default, weaker, stronger or maximum drive.
// - the output data drive field uses the same drive encoding as the clock field.
// - doubling code 01 doubles only the clock driver current.
// - doubling code 10 doubles both data and clock driver currents.
// - doubling code 00 leaves both currents as programmed and the host never writes code 11.
// - the data termination field selects none or one of seven resistances.
// - the clock termination field uses the same resistance table as the data field.
// - the offset freeze bit stops estimation and keeps subtracting the last estimate.
`timescale 1ns/1ns
`include "conv_cfg.svh"

module converter_output_config_regs #(
  parameter int SAMPLE_W = 14
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sen_n,
  input wire logic sclk,
  input wire logic sdata,
  output logic serial_out_pin,
  output conv_pkg::drive_level_t clk_drive_level,
  output conv_pkg::drive_level_t data_drive_level,
  output logic [1:0] diff_driver_amps_setting,
  output logic [7:0] clk_amps_q,
  output logic [7:0] data_amps_q,
  output logic [8:0] data_term_ohms,
  output logic [8:0] clk_term_ohms,
  output logic offset_frozen,
  input wire logic sample_valid,
  input wire logic signed [SAMPLE_W-1:0] sample_in,
  output logic sample_out_valid,
  output logic signed [SAMPLE_W:0] sample_out
);

  typedef struct packed {
    logic [1:0] sen_s;
    logic [2:0] sclk_s;
    logic [1:0] sdat_s;
    conv_pkg::frame_state_t state;
    logic [4:0] cnt;
    logic [14:0] shin;
    logic [7:0] shout;
    logic sdo;
    conv_pkg::cfg_t cfg;
    conv_pkg::drive_level_t clk_drv;
    conv_pkg::drive_level_t dat_drv;
    logic [7:0] clk_amps;
    logic [7:0] dat_amps;
    logic [8:0] dat_ohm;
    logic [8:0] clk_ohm;
  } bank_t;

  bank_t s_reg;
  bank_t s_next;
  logic active;
  logic rise;
  logic fall;
  logic wr_fire;
  logic [15:0] wr_word;
  logic [7:0] base_amps;

  // ****************************************************************
  // decoders
  // ****************************************************************
  function automatic conv_pkg::drive_level_t drive_level(input logic [1:0] code);
    case (code)
      2'h0: drive_level = conv_pkg::DRV_DEFAULT;
      2'h1: drive_level = conv_pkg::DRV_WEAK;
      2'h3: drive_level = conv_pkg::DRV_STRONG;
      default: drive_level = conv_pkg::DRV_MAX;
    endcase
  endfunction : drive_level

  function automatic logic [8:0] term_ohms(input logic [2:0] code);
    case (code)
      3'h1: term_ohms = `OHMS_CODE1;
      3'h2: term_ohms = `OHMS_CODE2;
      3'h3: term_ohms = `OHMS_CODE3;
      3'h4: term_ohms = `OHMS_CODE4;
      3'h5: term_ohms = `OHMS_CODE5;
      3'h6: term_ohms = `OHMS_CODE6;
      3'h7: term_ohms = `OHMS_CODE7;
      default: term_ohms = `OHMS_CODE0;
    endcase
  endfunction : term_ohms

  function automatic logic [7:0] read_value(input conv_pkg::cfg_t c, input logic [7:0] addr);
    read_value = 8'h00;
    case (addr)
      `REG_RESET_READBACK: read_value[`BIT_READBACK] = c.readback_en;
      `REG_CLK_DRIVE: read_value[`POS_CLK_STR_HI:`POS_CLK_STR_LO] = c.clk_str;
      `REG_DRIVER: begin
        read_value[`POS_DBL_HI:`POS_DBL_LO] = c.dbl;
        read_value[`POS_AMPS_HI:`POS_AMPS_LO] = c.amps;
        read_value[`POS_DAT_STR_HI:`POS_DAT_STR_LO] = c.dat_str;
      end
      `REG_TERM: begin
        read_value[`POS_DTERM_HI:`POS_DTERM_LO] = c.dterm;
        read_value[`POS_CTERM_HI:`POS_CTERM_LO] = c.cterm;
      end
      `REG_OFFSET_HOLD: read_value[`BIT_FREEZE] = c.freeze;
      default: read_value = 8'h00;
    endcase
  endfunction : read_value

  assign active = ~s_reg.sen_s[1];
  assign rise = s_reg.sclk_s[1] & ~s_reg.sclk_s[2];
  assign fall = ~s_reg.sclk_s[1] & s_reg.sclk_s[2];
  assign wr_word = {s_reg.shin, s_reg.sdat_s[1]};

  always_comb begin
    case (s_reg.cfg.amps)
      2'h0: base_amps = `AMPS_CODE0;
      2'h1: base_amps = `AMPS_CODE1;
      2'h2: base_amps = `AMPS_CODE2;
      default: base_amps = `AMPS_CODE3;
    endcase
  end

  // ****************************************************************
  // serial frame, register writes and decoded settings
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    wr_fire = 1'b0;
    s_next.sen_s = {s_reg.sen_s[0], sen_n};
    s_next.sclk_s = {s_reg.sclk_s[1:0], sclk};
    s_next.sdat_s = {s_reg.sdat_s[0], sdata};
    case (s_reg.state)
      conv_pkg::FR_IDLE: begin
        s_next.sdo = `SDO_FIXED_LEVEL;
        if (active) begin
          s_next.cnt = 5'h00;
          s_next.state = conv_pkg::FR_ADDR;
        end
      end
      conv_pkg::FR_ADDR: begin
        if (!active) begin
          s_next.state = conv_pkg::FR_IDLE;
        end else if (rise) begin
          s_next.shin = wr_word[14:0];
          s_next.cnt = s_reg.cnt + 5'h01;
          if (s_reg.cnt == `ADDR_BITS - 5'h01) begin
            s_next.state = conv_pkg::FR_DATA;
            s_next.shout = read_value(s_reg.cfg, wr_word[7:0]);
          end
        end
      end
      conv_pkg::FR_DATA: begin
        if (!active) begin
          s_next.state = conv_pkg::FR_IDLE;
        end else begin
          if (rise) begin
            s_next.shin = wr_word[14:0];
            s_next.cnt = s_reg.cnt + 5'h01;
            if (s_reg.cnt == `FRAME_BITS - 5'h01) begin
              s_next.state = conv_pkg::FR_DONE;
              wr_fire = 1'b1;
            end
          end
          if (fall && s_reg.cfg.readback_en) begin
            s_next.sdo = s_reg.shout[7];
            s_next.shout = {s_reg.shout[6:0], 1'b0};
          end
        end
      end
      conv_pkg::FR_DONE: begin
        if (!active) begin
          s_next.state = conv_pkg::FR_IDLE;
        end
      end
      default: s_next.state = conv_pkg::FR_IDLE;
    endcase

    // all fields of the addressed register change together
    if (wr_fire && (!s_reg.cfg.readback_en || wr_word[15:8] == `REG_RESET_READBACK)) begin
      case (wr_word[15:8])
        `REG_RESET_READBACK: begin
          if (wr_word[`BIT_SOFT_RESET]) begin
            s_next.cfg = `CFG_RESET_VALUE;
          end else begin
            s_next.cfg.readback_en = wr_word[`BIT_READBACK];
          end
        end
        `REG_CLK_DRIVE: s_next.cfg.clk_str = wr_word[`POS_CLK_STR_HI:`POS_CLK_STR_LO];
        `REG_DRIVER: begin
          s_next.cfg.dbl = wr_word[`POS_DBL_HI:`POS_DBL_LO];
          s_next.cfg.amps = wr_word[`POS_AMPS_HI:`POS_AMPS_LO];
          s_next.cfg.dat_str = wr_word[`POS_DAT_STR_HI:`POS_DAT_STR_LO];
        end
        `REG_TERM: begin
          s_next.cfg.dterm = wr_word[`POS_DTERM_HI:`POS_DTERM_LO];
          s_next.cfg.cterm = wr_word[`POS_CTERM_HI:`POS_CTERM_LO];
        end
        `REG_OFFSET_HOLD: s_next.cfg.freeze = wr_word[`BIT_FREEZE];
        default: s_next.cfg = s_reg.cfg;
      endcase
    end

    if (!s_reg.cfg.readback_en) begin
      s_next.sdo = `SDO_FIXED_LEVEL;
    end

    s_next.clk_drv = drive_level(s_reg.cfg.clk_str);
    s_next.dat_drv = drive_level(s_reg.cfg.dat_str);
    s_next.clk_amps = base_amps;
    s_next.dat_amps = base_amps;
    if (s_reg.cfg.dbl == 2'h1 || s_reg.cfg.dbl == 2'h2) begin
      s_next.clk_amps = {base_amps[6:0], 1'b0};
    end
    if (s_reg.cfg.dbl == 2'h2) begin
      s_next.dat_amps = {base_amps[6:0], 1'b0};
    end
    s_next.dat_ohm = term_ohms(s_reg.cfg.dterm);
    s_next.clk_ohm = term_ohms(s_reg.cfg.cterm);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_reg <= '{sen_s: 2'h3, sclk_s: 3'h0, sdat_s: 2'h0, state: conv_pkg::FR_IDLE,
                 cnt: 5'h00, shin: 15'h0000, shout: 8'h00, sdo: `SDO_FIXED_LEVEL,
                 cfg: `CFG_RESET_VALUE, clk_drv: conv_pkg::DRV_DEFAULT,
                 dat_drv: conv_pkg::DRV_DEFAULT, clk_amps: `AMPS_CODE0,
                 dat_amps: `AMPS_CODE0, dat_ohm: `OHMS_CODE0, clk_ohm: `OHMS_CODE0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign serial_out_pin = s_reg.sdo;
  assign clk_drive_level = s_reg.clk_drv;
  assign data_drive_level = s_reg.dat_drv;
  assign diff_driver_amps_setting = s_reg.cfg.amps;
  assign clk_amps_q = s_reg.clk_amps;
  assign data_amps_q = s_reg.dat_amps;
  assign data_term_ohms = s_reg.dat_ohm;
  assign clk_term_ohms = s_reg.clk_ohm;
  assign offset_frozen = s_reg.cfg.freeze;

  // ****************************************************************
  // offset correction
  // ****************************************************************
  offset_tracker #(
    .W(SAMPLE_W)
  ) u_offset (
    .mclk(mclk),
    .rst_n(rst_n),
    .freeze(s_reg.cfg.freeze),
    .sample_valid(sample_valid),
    .sample_in(sample_in),
    .sample_out_valid(sample_out_valid),
    .sample_out(sample_out)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_soft_reset_clears: assert property (wr_fire && wr_word[15:8] == `REG_RESET_READBACK &&
    wr_word[`BIT_SOFT_RESET] |=> s_reg.cfg == `CFG_RESET_VALUE ##1 serial_out_pin == 1'h0)
    else $error("soft reset did not clear the bank");
  chk_serial_out_fixed: assert property (!s_reg.cfg.readback_en |=> serial_out_pin == 1'h0)
    else $error("serial out not fixed with readback off");
  chk_readout_shift: assert property (s_reg.cfg.readback_en && s_reg.state == conv_pkg::FR_DATA
    && active && fall |=> serial_out_pin == $past(s_reg.shout[7]))
    else $error("readout bit does not match register");
  chk_clk_drive_max: assert property (s_reg.cfg.clk_str == 2'h2 |=>
    clk_drive_level == conv_pkg::DRV_MAX)
    else $error("clock drive code 10 not maximum");
  chk_data_drive_weak: assert property (s_reg.cfg.dat_str == 2'h1 |=>
    data_drive_level == conv_pkg::DRV_WEAK)
    else $error("data drive code 01 not weaker");
  chk_amps_base: assert property (s_reg.cfg.amps == 2'h3 && s_reg.cfg.dbl == 2'h0 |=>
    clk_amps_q == 8'h07 && data_amps_q == 8'h07)
    else $error("driver current code 11 not 1.75 mA");
  chk_double_clk_only: assert property (s_reg.cfg.dbl == 2'h1 |=>
    clk_amps_q == {data_amps_q[6:0], 1'b0})
    else $error("clock current not doubled alone");
  chk_double_both: assert property (s_reg.cfg.dbl == 2'h2 && s_reg.cfg.amps == 2'h2 |=>
    clk_amps_q == 8'h24 && data_amps_q == 8'h24)
    else $error("both currents not doubled");
  chk_double_none: assert property (s_reg.cfg.dbl == 2'h0 |=> clk_amps_q == data_amps_q)
    else $error("current changed with doubling off");
  chk_term_data: assert property (s_reg.cfg.dterm == 3'h7 |=> data_term_ohms == 9'h03c)
    else $error("data termination 111 not 60 ohm");
  chk_term_clk: assert property (s_reg.cfg.cterm == 3'h0 ##1 s_reg.cfg.cterm == 3'h1 |=>
    $past(clk_term_ohms) == 9'h000 && clk_term_ohms == 9'h12c)
    else $error("clock termination table wrong");
  chk_multi_field: assert property (wr_fire && !s_reg.cfg.readback_en &&
    wr_word[15:8] == `REG_TERM |=> s_reg.cfg.dterm == $past(wr_word[5:3]) &&
    s_reg.cfg.cterm == $past(wr_word[2:0]))
    else $error("termination write lost a field");

  cov_readout_frame: cover property (s_reg.cfg.readback_en && s_reg.state == conv_pkg::FR_DATA && fall);
  cov_soft_reset: cover property (wr_fire && wr_word == 16'h0002);
  cov_freeze_set: cover property (!s_reg.cfg.freeze ##1 s_reg.cfg.freeze);

endmodule : converter_output_config_regs

// file: tb/cfg_host.sv
// host model driving the serial configuration pins of the output config bank
// assumes mclk is the device clock; the bench calls xfer hierarchically
`timescale 1ns/1ns

module cfg_host (
  input wire logic mclk,
  output logic sen_n,
  output logic sclk,
  output logic sdata,
  input wire logic serial_out_pin
);
  // sclk half period in mclk cycles, above the 3 cycle minimum
  localparam int HALF = 6;

  initial begin
    sen_n = 1'b1;
    sclk = 1'b0;
    sdata = 1'b0;
  end

  // one frame, address then data msb first; pin sampled just before each of the eight data bit rises
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
    logic [15:0] bits;
    bits = {a, d};
    rd = 8'h00;
    @(negedge mclk);
    sen_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdata = bits[15-i];
      repeat (HALF) @(negedge mclk);
      if (i >= 8) begin
        rd[15-i] = serial_out_pin;
      end
      sclk = 1'b1;
      repeat (HALF) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge mclk);
    sen_n = 1'b1;
    // released line shows the inverse of its last value
    sdata = ~sdata;
    repeat (10) @(negedge mclk);
  endtask : xfer
endmodule : cfg_host

// file: tb/tb.sv
// self-checking bench for the output configuration register bank
// assumes cfg_host drives the serial pins; samples driven here on falling edges
`timescale 1ns/1ns
`include "conv_cfg.svh"

module tb;
  logic mclk;
  logic rst_n;
  wire logic sen_n;
  wire logic sclk;
  wire logic sdata;
  logic serial_out_pin;
  conv_pkg::drive_level_t clk_drive_level;
  conv_pkg::drive_level_t data_drive_level;
  logic [1:0] diff_driver_amps_setting;
  logic [7:0] clk_amps_q;
  logic [7:0] data_amps_q;
  logic [8:0] data_term_ohms;
  logic [8:0] clk_term_ohms;
  logic offset_frozen;
  logic sample_valid;
  logic signed [13:0] sample_in;
  logic sample_out_valid;
  logic signed [14:0] sample_out;
  int n_errors;
  int checks;
  logic [7:0] rd;
  logic [7:0] a;
  logic [5:0] v;
  logic signed [21:0] acc;
  logic [7:0] amps [4] = '{`AMPS_CODE0, `AMPS_CODE1, `AMPS_CODE2, `AMPS_CODE3};
  logic [8:0] ohms [8] = '{`OHMS_CODE0, `OHMS_CODE1, `OHMS_CODE2, `OHMS_CODE3,
                           `OHMS_CODE4, `OHMS_CODE5, `OHMS_CODE6, `OHMS_CODE7};
  logic [7:0] rd_addr [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h05, 8'h11};
  logic [7:0] rd_exp [6] = '{8'hc0, 8'h2f, 8'h3f, 8'h10, 8'h00, 8'h2f};

  converter_output_config_regs uut (
    .mclk(mclk), .rst_n(rst_n), .sen_n(sen_n), .sclk(sclk), .sdata(sdata),
    .serial_out_pin(serial_out_pin), .clk_drive_level(clk_drive_level),
    .data_drive_level(data_drive_level), .diff_driver_amps_setting(diff_driver_amps_setting),
    .clk_amps_q(clk_amps_q), .data_amps_q(data_amps_q), .data_term_ohms(data_term_ohms),
    .clk_term_ohms(clk_term_ohms), .offset_frozen(offset_frozen),
    .sample_valid(sample_valid), .sample_in(sample_in),
    .sample_out_valid(sample_out_valid), .sample_out(sample_out)
  );

  cfg_host host (.mclk(mclk), .sen_n(sen_n), .sclk(sclk), .sdata(sdata),
    .serial_out_pin(serial_out_pin));

  always #10 mclk = ~mclk;

  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic conv_pkg::drive_level_t drv(input logic [1:0] c);
    case (c)
      2'b00: return conv_pkg::DRV_DEFAULT;
      2'b01: return conv_pkg::DRV_WEAK;
      2'b11: return conv_pkg::DRV_STRONG;
      default: return conv_pkg::DRV_MAX;
    endcase
  endfunction : drv

  task automatic chk_defaults();
    chk(clk_drive_level, conv_pkg::DRV_DEFAULT);
    chk(data_drive_level, conv_pkg::DRV_DEFAULT);
    chk(clk_amps_q, `AMPS_CODE0);
    chk(data_amps_q, `AMPS_CODE0);
    chk(data_term_ohms, `OHMS_CODE0);
    chk(clk_term_ohms, `OHMS_CODE0);
    chk(offset_frozen, 1'b0);
    chk(diff_driver_amps_setting, 2'b00);
    chk(serial_out_pin, `SDO_FIXED_LEVEL);
  endtask : chk_defaults

  // one sample against a model of the estimator; frz holds the estimate
  task automatic samp(input logic signed [13:0] x, input logic frz);
    logic signed [21:0] e;
    e = acc >>> `OFS_AVG_SHIFT;
    sample_in = x;
    sample_valid = 1'b1;
    @(negedge mclk);
    sample_valid = 1'b0;
    chk(sample_out_valid, 1'b1);
    chk(16'(sample_out), 16'(x - e));
    if (!frz) begin
      acc = acc + (x - e);
    end
    @(negedge mclk);
    chk(sample_out_valid, 1'b0);
  endtask : samp

  task automatic finish_test();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    sample_valid = 1'b0;
    sample_in = '0;
    n_errors = 0;
    checks = 0;
    acc = '0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk_defaults();
    $display("test reset_values done");
    for (int c = 0; c < 4; c++) begin
      host.xfer(`REG_CLK_DRIVE, {c[1:0], 6'h00}, rd);
      chk(clk_drive_level, drv(c[1:0]));
      chk(rd, 8'h00);
    end
    $display("test clock_drive done");
    // doubling code 11 is never written
    for (int i = 0; i < 48; i++) begin
      v = i[5:0];
      host.xfer(`REG_DRIVER, {2'b00, v}, rd);
      a = amps[v[3:2]];
      chk(data_drive_level, drv(v[1:0]));
      chk(diff_driver_amps_setting, v[3:2]);
      chk(clk_amps_q, (v[5:4] == 2'b01 || v[5:4] == 2'b10) ? {a[6:0], 1'b0} : a);
      chk(data_amps_q, (v[5:4] == 2'b10) ? {a[6:0], 1'b0} : a);
    end
    $display("test driver_current done");
    for (int i = 0; i < 64; i++) begin
      v = i[5:0];
      host.xfer(`REG_TERM, {2'b00, v}, rd);
      chk(data_term_ohms, ohms[v[5:3]]);
      chk(clk_term_ohms, ohms[v[2:0]]);
    end
    $display("test termination done");
    for (int i = 0; i < 40; i++) begin
      samp(14'h0400, 1'b0);
    end
    host.xfer(`REG_OFFSET_HOLD, 8'h10, rd);
    chk(offset_frozen, 1'b1);
    for (int i = 0; i < 8; i++) begin
      samp(14'h0400, 1'b1);
    end
    $display("test offset_freeze done");
    host.xfer(`REG_RESET_READBACK, 8'h01, rd);
    for (int i = 0; i < 6; i++) begin
      host.xfer(rd_addr[i], 8'h00, rd);
      chk(rd, rd_exp[i]);
    end
    $display("test readback done");
    host.xfer(`REG_RESET_READBACK, 8'h02, rd);
    chk_defaults();
    host.xfer(`REG_RESET_READBACK, 8'h01, rd);
    host.xfer(`REG_RESET_READBACK, 8'h01, rd);
    chk(rd, 8'h01);
    host.xfer(`REG_RESET_READBACK, 8'h00, rd);
    chk(serial_out_pin, `SDO_FIXED_LEVEL);
    $display("test soft_reset done");
    finish_test();
  end
endmodule : tb
